// ### pkg/bmw_pkg.sv
// What this block does
// - Bits 3:0 of the memory window bottom and bits 19:16 of the memory window top always read zero and ignore writes.
// - Bits 15:4 of the memory window bottom give address bits 31:20 of the window bottom, whose low 20 bits are zero.
// - Bits 31:20 of the memory window top give address bits 31:20 of the window top, whose low 20 bits are all ones.
// - Memory transactions are forwarded by whether their address lies in the 1 MB aligned and 1 MB grained memory window.
// - The low four bits of the prefetch window bottom and top are read only and read one, marking 64-bit support.
// - Bits 15:4 of the prefetch window bottom give address bits 31:20, low 20 bits zero, bits 63:32 from the high bottom.
// - Bits 31:20 of the prefetch window top give address bits 31:20, low 20 bits all ones, bits 63:32 from the high top.
// - A fully writable 32-bit register holds bits 63:32 of the prefetch window bottom.
// - Memory reads and writes are forwarded by whether their address lies in the 1 MB grained prefetch window.
// - A fully writable 32-bit register holds bits 63:32 of the prefetch window top.
package bmw_pkg;

	// ==========================================================
	// configuration access
	localparam int BMW_CFG_AW = 8;
	localparam int BMW_DW = 32;
	localparam int BMW_BE_W = 4;
	localparam int BMW_NREG = 4;

	// ==========================================================
	// register offsets, index order 0..3
	localparam logic [7:0] BMW_OFS_MEM_WIN = 8'h20;
	localparam logic [7:0] BMW_OFS_PF_WIN = 8'h24;
	localparam logic [7:0] BMW_OFS_PF_BOT_HI = 8'h28;
	localparam logic [7:0] BMW_OFS_PF_TOP_HI = 8'h2c;
	localparam logic [BMW_NREG-1:0][7:0] BMW_OFS = {
		BMW_OFS_PF_TOP_HI, BMW_OFS_PF_BOT_HI, BMW_OFS_PF_WIN, BMW_OFS_MEM_WIN};

	// ==========================================================
	// field layout
	localparam int BMW_FIELD_W = 12;
	localparam int BMW_BOT_LSB = 4;
	localparam int BMW_TOP_LSB = 20;
	localparam int BMW_IND_W = 4;
	localparam int BMW_TOP_IND_LSB = 16;
	localparam int BMW_GRAN_BITS = 20;
	localparam logic [BMW_GRAN_BITS-1:0] BMW_LOW_ZERO = 20'h00000;
	localparam logic [BMW_GRAN_BITS-1:0] BMW_LOW_ONES = 20'hfffff;
	localparam logic [31:0] BMW_HI_ZERO = 32'h0000_0000;
	localparam logic [BMW_IND_W-1:0] BMW_MEM_IND = 4'h0;
	localparam logic [BMW_IND_W-1:0] BMW_PF_IND = 4'h1;

	// ==========================================================
	// writable masks, read-only values, reset values
	localparam logic [31:0] BMW_RW_WIN = 32'hfff0_fff0;
	localparam logic [31:0] BMW_RW_HI = 32'hffff_ffff;
	localparam logic [BMW_NREG-1:0][31:0] BMW_RW_MASK = {
		BMW_RW_HI, BMW_RW_HI, BMW_RW_WIN, BMW_RW_WIN};
	localparam logic [BMW_NREG-1:0][31:0] BMW_RO_VAL = {
		32'h0000_0000, 32'h0000_0000,
		{12'h000, BMW_PF_IND, 12'h000, BMW_PF_IND},
		{12'h000, BMW_MEM_IND, 12'h000, BMW_MEM_IND}};
	localparam logic [31:0] BMW_REG_RST = 32'h0000_0000;
	localparam logic [31:0] BMW_UNMAPPED = 32'h0000_0000;

endpackage : bmw_pkg

// ### pkg/bmw_win_if.sv
// ==========================================================
// one address window and the address tested against it
interface bmw_win_if;
	logic [63:0] bottom;
	logic [63:0] top;
	logic [63:0] addr;
	logic hit;

	modport owner (output bottom, output top, output addr, input hit);
	modport cmp (input bottom, input top, input addr, output hit);
endinterface : bmw_win_if

// ### hw/bmw_win_cmp.sv
// ==========================================================
// inclusive window compare
module bmw_win_cmp (
	bmw_win_if.cmp win
);
	import bmw_pkg::*;

	always_comb begin
		win.hit = (win.addr >= win.bottom) && (win.addr <= win.top);
	end

endmodule // bmw_win_cmp

// ### hw/bmw_regs.sv
module bmw_regs (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_cfg_rd,
	input wire logic i_cfg_wr,
	input wire logic [bmw_pkg::BMW_CFG_AW-1:0] i_cfg_addr,
	input wire logic [bmw_pkg::BMW_BE_W-1:0] i_cfg_be_n,
	input wire logic [bmw_pkg::BMW_DW-1:0] i_cfg_wdata,
	output logic [bmw_pkg::BMW_DW-1:0] o_cfg_rdata,
	output logic o_cfg_rvalid,
	input wire logic i_chk_valid,
	input wire logic i_chk_up,
	input wire logic [63:0] i_chk_addr,
	output logic o_chk_done,
	output logic o_chk_fwd,
	output logic o_chk_mem_hit,
	output logic o_chk_pf_hit
);
	import bmw_pkg::*;

	// ==========================================================
	// storage: only writable bits are kept, indicators are ORed in on read
	logic [31:0] win_reg [BMW_NREG];
	logic [31:0] win_next [BMW_NREG];
	logic [31:0] be_mask;
	logic [5:0] dw_addr;

	always_comb begin
		for (int b = 0; b < BMW_BE_W; b++) begin
			be_mask[b*8 +: 8] = {8{~i_cfg_be_n[b]}};
		end
		dw_addr = i_cfg_addr[7:2];
	end

	for (genvar r = 0; r < BMW_NREG; r++) begin : g_reg
		logic sel;
		logic [31:0] wmask;

		always_comb begin
			sel = i_cfg_wr && (dw_addr == BMW_OFS[r][7:2]);
			wmask = be_mask & BMW_RW_MASK[r];
			win_next[r] = win_reg[r];
			if (sel) begin
				win_next[r] = (win_reg[r] & ~wmask) | (i_cfg_wdata & wmask);
			end
		end

		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				win_reg[r] <= BMW_REG_RST;
			end else begin
				win_reg[r] <= win_next[r];
			end
		end
	end

	// ==========================================================
	// configuration read
	logic [31:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;

	always_comb begin
		rdata_next = rdata_reg;
		rvalid_next = i_cfg_rd;
		if (i_cfg_rd) begin
			rdata_next = BMW_UNMAPPED;
			for (int r = 0; r < BMW_NREG; r++) begin
				if (dw_addr == BMW_OFS[r][7:2]) begin
					rdata_next = (win_reg[r] & BMW_RW_MASK[r]) | BMW_RO_VAL[r];
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_reg <= BMW_REG_RST;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign o_cfg_rdata = rdata_reg;
	assign o_cfg_rvalid = rvalid_reg;

	// ==========================================================
	// window limits
	bmw_win_if mem_if ();
	bmw_win_if pf_if ();

	logic [BMW_FIELD_W-1:0] mem_bot_field;
	logic [BMW_FIELD_W-1:0] mem_top_field;
	logic [BMW_FIELD_W-1:0] pf_bot_field;
	logic [BMW_FIELD_W-1:0] pf_top_field;

	always_comb begin
		mem_bot_field = win_reg[0][BMW_BOT_LSB +: BMW_FIELD_W];
		mem_top_field = win_reg[0][BMW_TOP_LSB +: BMW_FIELD_W];
		pf_bot_field = win_reg[1][BMW_BOT_LSB +: BMW_FIELD_W];
		pf_top_field = win_reg[1][BMW_TOP_LSB +: BMW_FIELD_W];
		mem_if.bottom = {BMW_HI_ZERO, mem_bot_field, BMW_LOW_ZERO};
		mem_if.top = {BMW_HI_ZERO, mem_top_field, BMW_LOW_ONES};
		pf_if.bottom = {win_reg[2], pf_bot_field, BMW_LOW_ZERO};
		pf_if.top = {win_reg[3], pf_top_field, BMW_LOW_ONES};
		mem_if.addr = i_chk_addr;
		pf_if.addr = i_chk_addr;
	end

	bmw_win_cmp u_mem_cmp (
		.win(mem_if.cmp)
	);

	bmw_win_cmp u_pf_cmp (
		.win(pf_if.cmp)
	);

	// ==========================================================
	// forwarding decision
	// downstream claims window hits, upstream claims everything else
	logic done_reg, done_next;
	logic fwd_reg, fwd_next;
	logic mem_hit_reg, mem_hit_next;
	logic pf_hit_reg, pf_hit_next;

	always_comb begin
		done_next = i_chk_valid;
		fwd_reg_hold: begin
			fwd_next = fwd_reg;
			mem_hit_next = mem_hit_reg;
			pf_hit_next = pf_hit_reg;
		end
		if (i_chk_valid) begin
			mem_hit_next = mem_if.hit;
			pf_hit_next = pf_if.hit;
			fwd_next = (mem_if.hit || pf_if.hit) ^ i_chk_up;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			done_reg <= 1'b0;
			fwd_reg <= 1'b0;
			mem_hit_reg <= 1'b0;
			pf_hit_reg <= 1'b0;
		end else begin
			done_reg <= done_next;
			fwd_reg <= fwd_next;
			mem_hit_reg <= mem_hit_next;
			pf_hit_reg <= pf_hit_next;
		end
	end

	assign o_chk_done = done_reg;
	assign o_chk_fwd = fwd_reg;
	assign o_chk_mem_hit = mem_hit_reg;
	assign o_chk_pf_hit = pf_hit_reg;

	// ==========================================================
	// assertions
	logic full_wr;
	assign full_wr = i_cfg_wr && (i_cfg_be_n == 4'h0);

	AST_MEM_RO_ZERO: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_cfg_wr && dw_addr == BMW_OFS_MEM_WIN[7:2]) ##1 (i_cfg_rd && dw_addr == BMW_OFS_MEM_WIN[7:2])
		|=> (o_cfg_rvalid && o_cfg_rdata[3:0] == 4'h0 && o_cfg_rdata[19:16] == 4'h0))
		else $error("memory window indicator bits not zero");

	AST_MEM_BOT_FIELD: assert property (@(posedge i_clk) disable iff (i_rst)
		(full_wr && dw_addr == BMW_OFS_MEM_WIN[7:2])
		|=> (mem_if.bottom[31:20] == $past(i_cfg_wdata[15:4]) && mem_if.bottom[19:0] == 20'h00000
			&& mem_if.bottom[63:32] == 32'h0000_0000))
		else $error("memory window bottom not taken from bits 15:4");

	AST_MEM_TOP_FIELD: assert property (@(posedge i_clk) disable iff (i_rst)
		(full_wr && dw_addr == BMW_OFS_MEM_WIN[7:2])
		|=> (mem_if.top[31:20] == $past(i_cfg_wdata[31:20]) && mem_if.top[19:0] == 20'hfffff))
		else $error("memory window top not taken from bits 31:20");

	AST_MEM_FWD: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_chk_valid && !i_chk_up && i_chk_addr[63:32] == 32'h0000_0000
			&& i_chk_addr[31:20] >= mem_bot_field && i_chk_addr[31:20] <= mem_top_field)
		|=> (o_chk_done && o_chk_fwd && o_chk_mem_hit))
		else $error("downstream address in memory window not forwarded");

	AST_PF_IND: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_cfg_rd && dw_addr == BMW_OFS_PF_WIN[7:2])
		|=> (o_cfg_rdata[3:0] == 4'h1 && o_cfg_rdata[19:16] == 4'h1))
		else $error("prefetch window indicator bits not one");

	AST_PF_BOT: assert property (@(posedge i_clk) disable iff (i_rst)
		(full_wr && dw_addr == BMW_OFS_PF_WIN[7:2]) ##1 !i_cfg_wr
		|=> (pf_if.bottom[31:20] == $past(i_cfg_wdata[15:4], 2) && pf_if.bottom[19:0] == 20'h00000))
		else $error("prefetch window bottom wrong");

	AST_PF_TOP: assert property (@(posedge i_clk) disable iff (i_rst)
		(full_wr && dw_addr == BMW_OFS_PF_WIN[7:2])
		|=> (pf_if.top[31:20] == $past(i_cfg_wdata[31:20]) && pf_if.top[19:0] == 20'hfffff))
		else $error("prefetch window top wrong");

	AST_PF_BOT_HI: assert property (@(posedge i_clk) disable iff (i_rst)
		(full_wr && dw_addr == BMW_OFS_PF_BOT_HI[7:2]) ##1 (i_cfg_rd && dw_addr == BMW_OFS_PF_BOT_HI[7:2]
			&& !i_cfg_wr)
		|=> (o_cfg_rdata == $past(i_cfg_wdata, 2) && pf_if.bottom[63:32] == $past(i_cfg_wdata, 2)))
		else $error("prefetch high bottom not stored");

	AST_PF_FWD_UP: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_chk_valid && i_chk_up && i_chk_addr >= pf_if.bottom && i_chk_addr <= pf_if.top)
		|=> (o_chk_done && !o_chk_fwd && o_chk_pf_hit))
		else $error("upstream address in prefetch window forwarded");

	AST_PF_TOP_HI: assert property (@(posedge i_clk) disable iff (i_rst)
		(full_wr && dw_addr == BMW_OFS_PF_TOP_HI[7:2])
		|=> (pf_if.top[63:32] == $past(i_cfg_wdata)))
		else $error("prefetch high top not stored");

	AST_RESET_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(i_rst) |-> (mem_if.bottom == 64'h0 && pf_if.top == 64'h0000_0000_000f_ffff
			&& !o_cfg_rvalid && !o_chk_done))
		else $error("window fields not cleared by reset");

	AST_INCL_EDGES: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_chk_valid && (i_chk_addr == mem_if.bottom || i_chk_addr == mem_if.top)
			&& mem_if.bottom <= mem_if.top)
		|=> o_chk_mem_hit)
		else $error("window edge not treated as inside");

	AST_DONE_PULSE: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_chk_valid |=> !o_chk_done)
		else $error("check done without request");

	// ==========================================================
	// bus timing, held outputs and window edges

	logic rd_mapped;
	assign rd_mapped = (dw_addr == BMW_OFS_MEM_WIN[7:2]) || (dw_addr == BMW_OFS_PF_WIN[7:2])
		|| (dw_addr == BMW_OFS_PF_BOT_HI[7:2]) || (dw_addr == BMW_OFS_PF_TOP_HI[7:2]);

	AST_RD_ANSWER: assert property (@(posedge i_clk) disable iff (i_rst)
		i_cfg_rd |=> o_cfg_rvalid)
		else $error("read answer not one cycle after request");

	AST_RVALID_PULSE: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_cfg_rd |=> !o_cfg_rvalid)
		else $error("read answer without request");

	AST_RDATA_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_cfg_rd |=> $stable(o_cfg_rdata))
		else $error("read data changed without a read");

	AST_UNMAPPED_ZERO: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_cfg_rd && !rd_mapped) |=> (o_cfg_rdata == 32'h0000_0000))
		else $error("unmapped read not zero");

	AST_MEM_BOT_LANE: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_cfg_wr && dw_addr == BMW_OFS_MEM_WIN[7:2] && i_cfg_be_n[1])
		|=> (mem_if.bottom[31:24] == $past(mem_if.bottom[31:24])))
		else $error("memory window bottom changed by a disabled lane");

	AST_MEM_TOP_LANE: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_cfg_wr && dw_addr == BMW_OFS_MEM_WIN[7:2] && i_cfg_be_n[3])
		|=> (mem_if.top[31:24] == $past(mem_if.top[31:24])))
		else $error("memory window top changed by a disabled lane");

	AST_MEM_OUTSIDE: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_chk_valid && (i_chk_addr < mem_if.bottom || i_chk_addr > mem_if.top))
		|=> !o_chk_mem_hit)
		else $error("address outside memory window reported inside");

	AST_PF_OUTSIDE: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_chk_valid && (i_chk_addr < pf_if.bottom || i_chk_addr > pf_if.top))
		|=> !o_chk_pf_hit)
		else $error("address outside prefetch window reported inside");

	AST_PF_FWD_DOWN: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_chk_valid && !i_chk_up && i_chk_addr[63:32] == win_reg[2] && i_chk_addr[63:32] == win_reg[3]
			&& i_chk_addr[31:20] >= pf_bot_field && i_chk_addr[31:20] <= pf_top_field)
		|=> (o_chk_done && o_chk_fwd && o_chk_pf_hit))
		else $error("downstream address in prefetch window not forwarded");

	AST_UP_MISS_FWD: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_chk_valid && i_chk_up && !mem_if.hit && !pf_if.hit)
		|=> (o_chk_fwd && !o_chk_mem_hit && !o_chk_pf_hit))
		else $error("upstream address outside windows not forwarded");

	AST_DECISION_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_chk_valid |=> ($stable(o_chk_fwd) && $stable(o_chk_mem_hit) && $stable(o_chk_pf_hit)))
		else $error("forward decision changed without a query");

	AST_RST_OUTPUTS: assert property (@(posedge i_clk)
		i_rst |=> (mem_if.bottom == 64'h0 && pf_if.bottom == 64'h0 && o_cfg_rdata == 32'h0
			&& !o_cfg_rvalid && !o_chk_done && !o_chk_fwd))
		else $error("reset did not clear windows and outputs");

	COV_MEM_HIT: cover property (@(posedge i_clk) disable iff (i_rst)
		o_chk_done && o_chk_mem_hit && o_chk_fwd);
	COV_PF_HIT_64: cover property (@(posedge i_clk) disable iff (i_rst)
		o_chk_done && o_chk_pf_hit && $past(i_chk_addr[63:32]) != 32'h0000_0000);
	COV_UP_FWD: cover property (@(posedge i_clk) disable iff (i_rst)
		o_chk_done && o_chk_fwd && $past(i_chk_up));
	COV_PART_WRITE: cover property (@(posedge i_clk) disable iff (i_rst)
		i_cfg_wr && i_cfg_be_n == 4'hc && dw_addr == BMW_OFS_PF_WIN[7:2]);

endmodule // bmw_regs

// ### verif/bmw_cfg_host.sv
// ==========================================================
// configuration host on the primary side
module bmw_cfg_host (
	input wire logic i_clk,
	input wire logic i_rvalid,
	input wire logic [bmw_pkg::BMW_DW-1:0] i_rdata,
	output logic o_rd,
	output logic o_wr,
	output logic [bmw_pkg::BMW_CFG_AW-1:0] o_addr,
	output logic [bmw_pkg::BMW_BE_W-1:0] o_be_n,
	output logic [bmw_pkg::BMW_DW-1:0] o_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import bmw_pkg::*;

	initial begin
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_addr = 8'h00;
		o_be_n = 4'hf;
		o_wdata = 32'h0;
	end

	// one-cycle write strobe; idle data shows the inverse of the last value
	task automatic wr(input logic [7:0] a, input logic [3:0] be_n, input logic [31:0] d);
		o_wr = 1'b1;
		o_addr = a;
		o_be_n = be_n;
		o_wdata = d;
		@(posedge i_clk);
		#1;
		o_wr = 1'b0;
		o_be_n = ~be_n;
		o_wdata = ~d;
		@(posedge i_clk);
		#1;
	endtask

	// read strobe, then a bounded wait for the answer strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] q, output bit ok);
		int n;
		o_rd = 1'b1;
		o_addr = a;
		ok = 1'b0;
		q = 32'h0;
		@(posedge i_clk);
		#1;
		o_rd = 1'b0;
		for (n = 0; n < 4 && !ok; n++) begin
			if (i_rvalid === 1'b1) begin
				ok = 1'b1;
				q = i_rdata;
			end else begin
				@(posedge i_clk);
				#1;
			end
		end
		@(posedge i_clk);
		#1;
	endtask
endmodule // bmw_cfg_host

// ### verif/bmw_regs_tb.sv
module bmw_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import bmw_pkg::*;

	logic clk, rst, cv, cu, rvalid, done, fwd, mh, ph, rd, wr;
	logic [7:0] addr;
	logic [3:0] be_n;
	logic [31:0] wdata, rdata, r, d;
	logic [63:0] ca;
	logic [63:0] aq[$];
	logic [31:0] mdl[4];
	int miscompares, n_tests;

	wire [63:0] mb = {32'h0, mdl[0][15:4], 20'h00000};
	wire [63:0] mt = {32'h0, mdl[0][31:20], 20'hfffff};
	wire [63:0] pb = {mdl[2], mdl[1][15:4], 20'h00000};
	wire [63:0] pt = {mdl[3], mdl[1][31:20], 20'hfffff};

	always #2 clk = ~clk;

	bmw_regs i_dut (.i_clk(clk), .i_rst(rst), .i_cfg_rd(rd), .i_cfg_wr(wr),
		.i_cfg_addr(addr), .i_cfg_be_n(be_n), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
		.o_cfg_rvalid(rvalid), .i_chk_valid(cv), .i_chk_up(cu), .i_chk_addr(ca),
		.o_chk_done(done), .o_chk_fwd(fwd), .o_chk_mem_hit(mh), .o_chk_pf_hit(ph));
	bmw_cfg_host i_host (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_rd(rd),
		.o_wr(wr), .o_addr(addr), .o_be_n(be_n), .o_wdata(wdata));

	// ==========================================================
	// verdict and compares
	task automatic close_out();
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t read %h got %h exp %h", $time, a, got, exp);
		end
	endtask

	task automatic chk_q(input logic [63:0] a, input logic [3:0] got, input logic [3:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t query %h got %b exp %b", $time, a, got, exp);
		end
	endtask

	// ==========================================================
	// expectations from the register model
	function automatic logic [31:0] exp_rd(input logic [7:0] a);
		for (int i = 0; i < 4; i++) begin
			if (a[7:2] == BMW_OFS[i][7:2]) begin
				return mdl[i] | BMW_RO_VAL[i];
			end
		end
		return 32'h0;
	endfunction

	function automatic logic [2:0] exp_q(input logic up, input logic [63:0] a);
		logic m;
		logic p;
		m = (a >= mb) && (a <= mt);
		p = (a >= pb) && (a <= pt);
		return {(m | p) ^ up, m, p};
	endfunction

	task automatic do_wr(input logic [7:0] a, input logic [3:0] bn, input logic [31:0] v);
		logic [31:0] m;
		i_host.wr(a, bn, v);
		for (int i = 0; i < 4; i++) begin
			m = BMW_RW_MASK[i] & {{8{!bn[3]}}, {8{!bn[2]}}, {8{!bn[1]}}, {8{!bn[0]}}};
			if (a[7:2] == BMW_OFS[i][7:2]) begin
				mdl[i] = (mdl[i] & ~m) | (v & m);
			end
		end
	endtask

	task automatic do_rd(input logic [7:0] a);
		logic [31:0] q;
		bit ok;
		i_host.rd(a, q, ok);
		if (!ok) begin
			miscompares++;
			$display("[FAIL] %0t no read answer", $time);
			close_out();
		end else begin
			chk_rd(a, q, exp_rd(a));
		end
	endtask

	// valid stays high across back-to-back queries; caller lowers it
	task automatic do_q(input logic up, input logic [63:0] a);
		cv = 1'b1;
		cu = up;
		ca = a;
		@(posedge clk);
		#1;
		chk_q(a, {done, fwd, mh, ph}, {1'b1, exp_q(up, a)});
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		cv = 1'b0;
		cu = 1'b0;
		ca = 64'h0;
		miscompares = 0;
		n_tests = 0;
		foreach (mdl[i]) mdl[i] = 32'h0;
		void'($urandom(71));
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int i = 0; i < 4; i++) begin
			do_rd(BMW_OFS[i]);
		end
		do_rd(8'h1c);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			do_wr(BMW_OFS[i], 4'h0, 32'hffffffff);
			do_rd(BMW_OFS[i]);
		end
		do_wr(8'h30, 4'h0, 32'hffffffff);
		do_rd(8'h30);
		$display("test all ones done");
		repeat (40) begin
			r = $urandom();
			do_wr(BMW_OFS[r[5:4]], r[3:0], $urandom());
			do_rd(BMW_OFS[r[9:8]]);
		end
		$display("test byte lanes done");
		repeat (30) begin
			r = $urandom();
			d = $urandom();
			do_wr(BMW_OFS[0], 4'h0, $urandom());
			do_wr(BMW_OFS[1], 4'h0, $urandom());
			do_wr(BMW_OFS[2], 4'h0, d);
			do_wr(BMW_OFS[3], 4'h0, d + {31'h0, r[0]});
			aq = {mb, mb - 1, mt, mt + 1, pb, pb - 1, pt, pt + 1, {d, r}};
			foreach (aq[i]) begin
				do_q(1'b0, aq[i]);
				do_q(1'b1, aq[i]);
			end
			cv = 1'b0;
			ca = ~ca;
		end
		$display("test windows done");
		rst = 1'b1;
		@(posedge clk);
		#1;
		rst = 1'b0;
		foreach (mdl[i]) mdl[i] = 32'h0;
		for (int i = 0; i < 4; i++) begin
			do_rd(BMW_OFS[i]);
		end
		do_q(1'b0, 64'h0);
		cv = 1'b0;
		$display("test second reset done");
		close_out();
	end
endmodule // bmw_regs_tb
